/* File: hw/pac_defines.svh */
// register offsets, control bit positions, reset values and field codes
// assumes an 8-bit register address and 32-bit register data
`ifndef PAC_DEFINES_SVH
`define PAC_DEFINES_SVH

`define PAC_ADDR_W 8
`define PAC_OFF_CTRL 8'h00
`define PAC_OFF_EGRESS 8'h04
`define PAC_OFF_BUS 8'h08
`define PAC_OFF_VCOUNT 8'h0C
`define PAC_OFF_HDR0 8'h10
`define PAC_OFF_HDR1 8'h14
`define PAC_OFF_HDR2 8'h18

`define PAC_BIT_SRCVAL 0
`define PAC_BIT_XBLOCK 1
`define PAC_BIT_REQRED 2
`define PAC_BIT_CPLRED 3
`define PAC_BIT_UPFWD 4
`define PAC_BIT_EGRESS 5
`define PAC_BIT_DIRXL 6
`define PAC_CTRL_W 7

`define PAC_CTRL_RST 7'h00
`define PAC_BUS_RST 8'h00
`define PAC_VCOUNT_RST 16'h0000
`define PAC_AT_UNTRANS 2'h0
`define PAC_AT_XREQ 2'h1
`define PAC_AT_XLATED 2'h2

`endif

/* File: hw/pac_pkg.sv */
// types shared by the access-control router and its decision module
// assumes packet fields are already parsed by the transaction layer
package pac_pkg;

  // where the block sits in the hierarchy
  typedef enum logic [1:0] {
    PAC_ROOT_PORT,
    PAC_SWITCH_DSP,
    PAC_MFD_FUNC
  } pac_kind_e;

  typedef enum logic [1:0] {
    PAC_ROUTE,
    PAC_UPSTREAM,
    PAC_VALIDATE,
    PAC_BLOCK
  } pac_outcome_e;

  typedef struct packed {
    logic is_req;
    logic is_cpl;
    logic is_mem;
    logic is_read_cpl;
    logic non_posted;
    logic upstream;
    logic peer;
    logic own_egress;
    logic [1:0] at;
    logic ro;
    logic [7:0] req_bus;
    logic [2:0] req_func;
    logic [2:0] tgt_port;
    logic [95:0] hdr;
  } pac_pkt_s;

endpackage

/* File: hw/pac_dec_if.sv */
// carries a packet and the live controls to the decision logic and back
// assumes one clock domain; the interface holds no state
`timescale 1ns/100ps
`include "pac_defines.svh"
interface pac_dec_if #(
  parameter int EGR_W = 8
);
  pac_pkg::pac_pkt_s pkt;
  logic [`PAC_CTRL_W-1:0] ctrl;
  logic [EGR_W-1:0] egress;
  logic [7:0] sec_bus;
  logic [7:0] sub_bus;
  pac_pkg::pac_outcome_e outcome;
  logic viol;

  modport router (output pkt, ctrl, egress, sec_bus, sub_bus, input outcome, viol);
  modport decide (input pkt, ctrl, egress, sec_bus, sub_bus, output outcome, viol);
endinterface

/* File: hw/pac_decide.sv */
// combinational outcome for one packet from the live access-control settings
// assumes the caller registers the result
`timescale 1ns/100ps
`include "pac_defines.svh"
module pac_decide #(
  parameter pac_pkg::pac_kind_e KIND = pac_pkg::PAC_SWITCH_DSP,
  parameter int EGR_W = 8
) (
  pac_dec_if.decide d
);
  // redirect goes to validation in a root port, upstream elsewhere
  function automatic pac_pkg::pac_outcome_e redir();
    return (KIND == pac_pkg::PAC_ROOT_PORT) ? pac_pkg::PAC_VALIDATE : pac_pkg::PAC_UPSTREAM;
  endfunction

  logic src_bad;
  logic xl_bad;
  logic vec_bit;
  logic [2:0] vidx;

  always_comb begin
    src_bad = d.ctrl[`PAC_BIT_SRCVAL] &&
      (d.pkt.req_bus < d.sec_bus || d.pkt.req_bus > d.sub_bus);
    xl_bad = d.ctrl[`PAC_BIT_XBLOCK] && d.pkt.is_mem && d.pkt.at != `PAC_AT_UNTRANS;
    // a function judges by the requester function, a port by the target port
    vidx = (KIND == pac_pkg::PAC_MFD_FUNC) ? d.pkt.req_func : d.pkt.tgt_port;
    vec_bit = (32'(vidx) < EGR_W) ? d.egress[vidx] : 1'b0;
    d.viol = 1'b0;
    d.outcome = pac_pkg::PAC_ROUTE;
    if (!d.pkt.upstream) begin
      d.outcome = pac_pkg::PAC_ROUTE;
    end else if (d.pkt.is_cpl) begin
      // only completion redirect and upstream forwarding touch completions
      if (d.pkt.peer && d.ctrl[`PAC_BIT_CPLRED] && d.pkt.is_read_cpl && !d.pkt.ro) begin
        d.outcome = redir();
      end else if (d.pkt.own_egress && d.ctrl[`PAC_BIT_UPFWD]) begin
        d.outcome = redir();
      end
    end else if (d.pkt.is_req) begin
      if (src_bad || xl_bad) begin
        d.outcome = pac_pkg::PAC_BLOCK;
        d.viol = 1'b1;
      end else if (d.pkt.own_egress && d.ctrl[`PAC_BIT_UPFWD]) begin
        d.outcome = redir();
      end else if (d.pkt.peer) begin
        if (d.ctrl[`PAC_BIT_DIRXL] && d.pkt.is_mem && d.pkt.at == `PAC_AT_XLATED) begin
          d.outcome = pac_pkg::PAC_ROUTE;
        end else if (d.ctrl[`PAC_BIT_REQRED] && (!d.ctrl[`PAC_BIT_EGRESS] || vec_bit)) begin
          d.outcome = redir();
        end else if (d.ctrl[`PAC_BIT_EGRESS] && vec_bit) begin
          d.outcome = pac_pkg::PAC_BLOCK;
          d.viol = 1'b1;
        end
      end
    end
  end
endmodule

/* File: hw/pac_router.sv */
// access-control router: registers, input stage, decision and violation report
// assumes parsed packet fields from the transaction layer on core_clk
`timescale 1ns/100ps
`include "pac_defines.svh"
// Overview of operation
// - all checks reset disabled until software enables
// - source check requester bus against bus aperture
// - completions ignore all but completion redirect, forwarding
// - translation blocking flags non-default address type
// - switch request redirect sends peer requests upstream
// - root port redirect sends to validation logic
// - never redirect downstream travelling packets
// - switch redirects non-relaxed peer read completions upstream
// - root port completion redirect keeps order via validation
// - completion and request controls stay independent
// - switch upstream forwarding of own-egress packets
// - root port forwarding treated like redirect
// - sending port egress controls block and report
// - translated peer memory requests route directly
// - function request redirect sends peer requests upstream
// - function completion redirect of non-relaxed reads
// - function egress judged by requester function number
// - function direct translated routing bypasses controls
// - functions lack source, translation, forwarding controls
// - bridge, collector, single-function parts never instantiate
// - egress, redirect, vector bit select the outcome
// - blocked non-posted request answered with completer abort
// - address type codes decoded as documented
module pac_router #(
  parameter pac_pkg::pac_kind_e KIND = pac_pkg::PAC_SWITCH_DSP,
  parameter int EGR_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [`PAC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pkt_valid,
  input wire pac_pkg::pac_pkt_s pkt_in,
  output logic dec_valid,
  output pac_pkg::pac_outcome_e dec_outcome,
  output logic viol_valid,
  output logic viol_ca_cpl,
  output logic [95:0] viol_hdr
);
  // controls a function of a multi-function device may not own
  function automatic logic [`PAC_CTRL_W-1:0] cap_mask();
    logic [`PAC_CTRL_W-1:0] m;
    m = '1;
    if (KIND == pac_pkg::PAC_MFD_FUNC) begin
      m[`PAC_BIT_SRCVAL] = 1'b0;
      m[`PAC_BIT_XBLOCK] = 1'b0;
      m[`PAC_BIT_UPFWD] = 1'b0;
    end
    return m;
  endfunction

  function automatic logic hit(input logic [`PAC_ADDR_W-1:0] off);
    return reg_addr == off;
  endfunction

  // register group
  logic [`PAC_CTRL_W-1:0] ctrl;
  logic [`PAC_CTRL_W-1:0] next_ctrl;
  logic [EGR_W-1:0] egress;
  logic [EGR_W-1:0] next_egress;
  logic [7:0] sec_bus;
  logic [7:0] next_sec_bus;
  logic [7:0] sub_bus;
  logic [7:0] next_sub_bus;
  logic [15:0] vcount;
  logic [15:0] next_vcount;
  logic [95:0] last_hdr;
  logic [95:0] next_last_hdr;
  logic [31:0] next_reg_rdata;

  // input stage
  logic s_valid;
  logic next_s_valid;
  pac_pkg::pac_pkt_s s_pkt;
  pac_pkg::pac_pkt_s next_s_pkt;

  // output stage
  logic next_dec_valid;
  pac_pkg::pac_outcome_e next_dec_outcome;
  logic next_viol_valid;
  logic next_viol_ca_cpl;
  logic [95:0] next_viol_hdr;

  pac_dec_if #(.EGR_W(EGR_W)) dif ();

  pac_decide #(
    .KIND(KIND),
    .EGR_W(EGR_W)
  ) u_decide (
    .d(dif.decide)
  );

  assign dif.pkt = s_pkt;
  assign dif.ctrl = ctrl;
  assign dif.egress = egress;
  assign dif.sec_bus = sec_bus;
  assign dif.sub_bus = sub_bus;

  logic viol_now;
  assign viol_now = s_valid && dif.viol;

  always_comb begin
    next_ctrl = ctrl;
    next_egress = egress;
    next_sec_bus = sec_bus;
    next_sub_bus = sub_bus;
    next_vcount = vcount;
    next_last_hdr = last_hdr;
    next_reg_rdata = 32'h00000000;
    if (reg_wr && hit(`PAC_OFF_CTRL)) begin
      next_ctrl = reg_wdata[`PAC_CTRL_W-1:0] & cap_mask();
    end
    if (reg_wr && hit(`PAC_OFF_EGRESS)) begin
      next_egress = reg_wdata[EGR_W-1:0];
    end
    if (reg_wr && hit(`PAC_OFF_BUS)) begin
      next_sec_bus = reg_wdata[7:0];
      next_sub_bus = reg_wdata[15:8];
    end
    // a violation in the clearing cycle still counts
    if (reg_wr && hit(`PAC_OFF_VCOUNT)) begin
      next_vcount = viol_now ? 16'h0001 : 16'h0000;
    end else if (viol_now && vcount != 16'hFFFF) begin
      next_vcount = vcount + 16'h0001;
    end
    if (viol_now) begin
      next_last_hdr = s_pkt.hdr;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `PAC_OFF_CTRL: next_reg_rdata = 32'(ctrl);
        `PAC_OFF_EGRESS: next_reg_rdata = 32'(egress);
        `PAC_OFF_BUS: next_reg_rdata = {16'h0000, sub_bus, sec_bus};
        `PAC_OFF_VCOUNT: next_reg_rdata = {16'h0000, vcount};
        `PAC_OFF_HDR0: next_reg_rdata = last_hdr[31:0];
        `PAC_OFF_HDR1: next_reg_rdata = last_hdr[63:32];
        `PAC_OFF_HDR2: next_reg_rdata = last_hdr[95:64];
        default: next_reg_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl <= `PAC_CTRL_RST;
      egress <= '0;
      sec_bus <= `PAC_BUS_RST;
      sub_bus <= `PAC_BUS_RST;
      vcount <= `PAC_VCOUNT_RST;
      last_hdr <= '0;
      reg_rdata <= 32'h00000000;
    end else begin
      ctrl <= next_ctrl;
      egress <= next_egress;
      sec_bus <= next_sec_bus;
      sub_bus <= next_sub_bus;
      vcount <= next_vcount;
      last_hdr <= next_last_hdr;
      reg_rdata <= next_reg_rdata;
    end
  end

  always_comb begin
    next_s_valid = pkt_valid;
    next_s_pkt = pkt_valid ? pkt_in : s_pkt;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_valid <= 1'b0;
      s_pkt <= '0;
    end else begin
      s_valid <= next_s_valid;
      s_pkt <= next_s_pkt;
    end
  end

  // exactly one outcome per staged packet
  always_comb begin
    next_dec_valid = s_valid;
    next_dec_outcome = s_valid ? dif.outcome : pac_pkg::PAC_ROUTE;
    next_viol_valid = viol_now;
    next_viol_ca_cpl = viol_now && s_pkt.non_posted;
    next_viol_hdr = viol_now ? s_pkt.hdr : viol_hdr;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dec_valid <= 1'b0;
      dec_outcome <= pac_pkg::PAC_ROUTE;
      viol_valid <= 1'b0;
      viol_ca_cpl <= 1'b0;
      viol_hdr <= '0;
    end else begin
      dec_valid <= next_dec_valid;
      dec_outcome <= next_dec_outcome;
      viol_valid <= next_viol_valid;
      viol_ca_cpl <= next_viol_ca_cpl;
      viol_hdr <= next_viol_hdr;
    end
  end

  // checking copies of the inputs that produced the current outcome
  pac_pkg::pac_pkt_s q_pkt;
  logic [`PAC_CTRL_W-1:0] q_ctrl;
  logic [7:0] q_sec;
  logic [7:0] q_sub;
  logic q_vec;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q_pkt <= '0;
      q_ctrl <= '0;
      q_sec <= 8'h00;
      q_sub <= 8'h00;
      q_vec <= 1'b0;
    end else begin
      q_pkt <= s_pkt;
      q_ctrl <= ctrl;
      q_sec <= sec_bus;
      q_sub <= sub_bus;
      q_vec <= egress[s_pkt.tgt_port];
    end
  end

  // redirect target for this kind of port, used by the checks below
  function automatic pac_pkg::pac_outcome_e redir_exp();
    return (KIND == pac_pkg::PAC_ROOT_PORT) ? pac_pkg::PAC_VALIDATE : pac_pkg::PAC_UPSTREAM;
  endfunction

  property p_reset_quiet;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_ctrl == `PAC_CTRL_RST |-> dec_outcome == pac_pkg::PAC_ROUTE;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("check acted while disabled");

  property p_src_range;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.upstream && q_pkt.is_req && q_ctrl[`PAC_BIT_SRCVAL]
      && (q_pkt.req_bus < q_sec || q_pkt.req_bus > q_sub)
      |-> dec_outcome == pac_pkg::PAC_BLOCK && viol_valid;
  endproperty
  a_src_range: assert property (p_src_range) else $error("bus outside aperture passed");

  property p_cpl_never_blocked;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.is_cpl |-> dec_outcome != pac_pkg::PAC_BLOCK && !viol_valid;
  endproperty
  a_cpl_never_blocked: assert property (p_cpl_never_blocked) else $error("completion blocked");

  property p_xlate_block;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.upstream && q_pkt.is_req && q_pkt.is_mem
      && q_ctrl[`PAC_BIT_XBLOCK] && q_pkt.at != `PAC_AT_UNTRANS
      |-> dec_outcome == pac_pkg::PAC_BLOCK;
  endproperty
  a_xlate_block: assert property (p_xlate_block) else $error("address type not blocked");

  property p_down_routed;
    @(posedge core_clk) disable iff (reset)
      dec_valid && !q_pkt.upstream |-> dec_outcome == pac_pkg::PAC_ROUTE && !viol_valid;
  endproperty
  a_down_routed: assert property (p_down_routed) else $error("downstream packet diverted");

  property p_cpl_redirect;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.upstream && q_pkt.is_cpl && q_pkt.peer && q_pkt.is_read_cpl
      && !q_pkt.ro && q_ctrl[`PAC_BIT_CPLRED]
      |-> dec_outcome == redir_exp();
  endproperty
  a_cpl_redirect: assert property (p_cpl_redirect) else $error("read completion not redirected");

  property p_direct_xl;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.upstream && q_pkt.is_req && q_pkt.peer && !q_pkt.own_egress
      && q_pkt.is_mem && q_pkt.at == `PAC_AT_XLATED && q_ctrl[`PAC_BIT_DIRXL]
      && !q_ctrl[`PAC_BIT_SRCVAL] && !q_ctrl[`PAC_BIT_XBLOCK]
      |-> dec_outcome == pac_pkg::PAC_ROUTE;
  endproperty
  a_direct_xl: assert property (p_direct_xl) else $error("translated request not direct");

  property p_egress_block;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.upstream && q_pkt.is_req && q_pkt.peer && !q_pkt.own_egress
      && KIND != pac_pkg::PAC_MFD_FUNC && q_vec && q_ctrl[`PAC_BIT_EGRESS]
      && !q_ctrl[`PAC_BIT_REQRED] && !q_ctrl[`PAC_BIT_DIRXL]
      && !q_ctrl[`PAC_BIT_SRCVAL] && !q_ctrl[`PAC_BIT_XBLOCK]
      |-> dec_outcome == pac_pkg::PAC_BLOCK && viol_valid;
  endproperty
  a_egress_block: assert property (p_egress_block) else $error("egress vector not enforced");

  property p_ca_on_np;
    @(posedge core_clk) disable iff (reset)
      viol_valid |-> viol_ca_cpl == q_pkt.non_posted && viol_hdr == q_pkt.hdr;
  endproperty
  a_ca_on_np: assert property (p_ca_on_np) else $error("abort completion mismatch");

  property p_one_outcome;
    @(posedge core_clk) disable iff (reset)
      s_valid |=> dec_valid ##0 (viol_valid -> dec_outcome == pac_pkg::PAC_BLOCK);
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("packet without outcome");

  property p_mfd_caps;
    @(posedge core_clk) disable iff (reset)
      KIND == pac_pkg::PAC_MFD_FUNC |-> !ctrl[`PAC_BIT_SRCVAL] && !ctrl[`PAC_BIT_UPFWD]
      && !ctrl[`PAC_BIT_XBLOCK];
  endproperty
  a_mfd_caps: assert property (p_mfd_caps) else $error("function holds forbidden control");

  property p_req_redirect;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.upstream && q_pkt.is_req && q_pkt.peer && !q_pkt.own_egress
      && q_ctrl[`PAC_BIT_REQRED] && !q_ctrl[`PAC_BIT_EGRESS] && !q_ctrl[`PAC_BIT_DIRXL]
      && !q_ctrl[`PAC_BIT_SRCVAL] && !q_ctrl[`PAC_BIT_XBLOCK]
      |-> dec_outcome == redir_exp();
  endproperty
  a_req_redirect: assert property (p_req_redirect) else $error("request not redirected");

  property p_upstream_fwd;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.upstream && q_pkt.own_egress && (q_pkt.is_req || q_pkt.is_cpl)
      && q_ctrl[`PAC_BIT_UPFWD] && !q_ctrl[`PAC_BIT_SRCVAL] && !q_ctrl[`PAC_BIT_XBLOCK]
      |-> dec_outcome == redir_exp();
  endproperty
  a_upstream_fwd: assert property (p_upstream_fwd) else $error("no forwarding");

  property p_cpl_untouched;
    @(posedge core_clk) disable iff (reset)
      dec_valid && q_pkt.is_cpl && !q_ctrl[`PAC_BIT_CPLRED] && !q_ctrl[`PAC_BIT_UPFWD]
      |-> dec_outcome == pac_pkg::PAC_ROUTE;
  endproperty
  a_cpl_untouched: assert property (p_cpl_untouched) else $error("completion diverted");

  property p_viol_blocks;
    @(posedge core_clk) disable iff (reset)
      viol_valid |-> dec_valid && dec_outcome == pac_pkg::PAC_BLOCK;
  endproperty
  a_viol_blocks: assert property (p_viol_blocks) else $error("violation without block");

endmodule

/* File: verif/pac_link_model.sv */
// link partner model: presents one parsed packet per request to the router
// assumes the bench raises send_req for one cycle per packet, right after an edge
`timescale 1ns/100ps
module pac_link_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic send_req,
  input wire pac_pkg::pac_pkt_s send_pkt,
  output logic pkt_valid,
  output pac_pkg::pac_pkt_s pkt_in
);
  pac_pkg::pac_pkt_s last_pkt;
  pac_pkg::pac_pkt_s next_last_pkt;

  // between packets the fields carry the inverse of the last packet, so stale data never matches
  always_comb begin
    pkt_valid = send_req;
    pkt_in = send_req ? send_pkt : pac_pkg::pac_pkt_s'(~last_pkt);
    next_last_pkt = send_req ? send_pkt : last_pkt;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      last_pkt <= '0;
    end else begin
      last_pkt <= next_last_pkt;
    end
  end
endmodule

/* File: verif/tb_pac_router.sv */
// self-checking bench for the access-control router: switch, root port and function forms
// assumes the link model feeds packets and the bench owns the register port
`timescale 1ns/100ps
`include "pac_defines.svh"
module tb_pac_router;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [`PAC_ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic send_req = 1'b0;
  pac_pkg::pac_pkt_s send_pkt = '0;
  logic pkt_valid;
  pac_pkg::pac_pkt_s pkt_in;
  logic dec_valid;
  pac_pkg::pac_outcome_e dec_outcome;
  logic viol_valid;
  logic viol_ca_cpl;
  logic [95:0] viol_hdr;
  pac_pkg::pac_outcome_e rp_outcome;
  logic [31:0] fn_rdata;
  int miscompares = 0;
  int checks = 0;
  int nviol = 0;
  logic [95:0] last_hdr = '0;

  always #12.5 core_clk = ~core_clk;

  pac_link_model u_pac_link_model (
    .core_clk(core_clk),
    .reset(reset),
    .send_req(send_req),
    .send_pkt(send_pkt),
    .pkt_valid(pkt_valid),
    .pkt_in(pkt_in)
  );

  pac_router #(
    .KIND(pac_pkg::PAC_SWITCH_DSP),
    .EGR_W(8)
  ) u_pac_router (
    .core_clk(core_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pkt_valid(pkt_valid),
    .pkt_in(pkt_in),
    .dec_valid(dec_valid),
    .dec_outcome(dec_outcome),
    .viol_valid(viol_valid),
    .viol_ca_cpl(viol_ca_cpl),
    .viol_hdr(viol_hdr)
  );

  // root port form: redirected traffic goes to validation
  if (1'b1) begin : g_root
    pac_router #(
      .KIND(pac_pkg::PAC_ROOT_PORT),
      .EGR_W(8)
    ) u_pac_router (
      .core_clk(core_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(),
      .pkt_valid(pkt_valid),
      .pkt_in(pkt_in),
      .dec_valid(),
      .dec_outcome(rp_outcome),
      .viol_valid(),
      .viol_ca_cpl(),
      .viol_hdr()
    );
  end

  // function form: forbidden controls must read back as zero
  if (1'b1) begin : g_func
    pac_router #(
      .KIND(pac_pkg::PAC_MFD_FUNC),
      .EGR_W(8)
    ) u_pac_router (
      .core_clk(core_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(fn_rdata),
      .pkt_valid(pkt_valid),
      .pkt_in(pkt_in),
      .dec_valid(),
      .dec_outcome(),
      .viol_valid(),
      .viol_ca_cpl(),
      .viol_hdr()
    );
  end

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check({64'h0, reg_rdata}, {64'h0, exp});
  endtask

  // same read, looked at on the function form
  task automatic rd_fn(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check({64'h0, fn_rdata}, {64'h0, exp});
  endtask

  // flags: peer, upstream, own egress, relaxed order, non-posted
  function automatic pac_pkg::pac_pkt_s mk(input logic cpl, input logic mem,
    input logic [1:0] at, input logic [7:0] bus, input logic [4:0] fl);
    pac_pkg::pac_pkt_s p;
    p = '0;
    p.is_req = ~cpl;
    p.is_cpl = cpl;
    p.is_mem = mem & ~cpl;
    p.is_read_cpl = mem & cpl;
    {p.peer, p.upstream, p.own_egress, p.ro, p.non_posted} = fl;
    p.at = at;
    p.req_bus = bus;
    p.req_func = 3'h3;
    p.tgt_port = 3'h3;
    p.hdr = {3{bus, 6'h00, at, 16'h5A5A}};
    return p;
  endfunction

  task automatic send(input pac_pkg::pac_pkt_s p, input pac_pkg::pac_outcome_e exp);
    logic blk;
    pac_pkg::pac_outcome_e rp_exp;
    blk = (exp == pac_pkg::PAC_BLOCK);
    rp_exp = (exp == pac_pkg::PAC_UPSTREAM) ? pac_pkg::PAC_VALIDATE : exp;
    @(posedge core_clk);
    send_req <= 1'b1;
    send_pkt <= p;
    @(posedge core_clk);
    send_req <= 1'b0;
    // staged at the edge above, outcome stands for the one cycle after the next edge
    @(posedge core_clk);
    #1;
    check({95'h0, dec_valid}, 96'h1);
    check({94'h0, dec_outcome}, {94'h0, exp});
    check({94'h0, rp_outcome}, {94'h0, rp_exp});
    check({95'h0, viol_valid}, {95'h0, blk});
    check({95'h0, viol_ca_cpl}, {95'h0, blk & p.non_posted});
    if (blk) begin
      nviol++;
      last_hdr = p.hdr;
      check(viol_hdr, p.hdr);
    end
  endtask

  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end

  initial begin
    logic e, r, v;
    pac_pkg::pac_outcome_e exp;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(`PAC_OFF_CTRL, 32'h0);
    rd(`PAC_OFF_EGRESS, 32'h0);
    rd(`PAC_OFF_BUS, 32'h0);
    rd(`PAC_OFF_VCOUNT, 32'h0);
    rd(8'h40, 32'h0);
    send(mk(1'b0, 1'b1, 2'h1, 8'h00, 5'h19), pac_pkg::PAC_ROUTE);
    $display("test reset_defaults done");
    wr(`PAC_OFF_BUS, 32'h0000_2010);
    wr(`PAC_OFF_CTRL, 32'h0000_00FF);
    rd(`PAC_OFF_CTRL, 32'h0000_007F);
    rd_fn(`PAC_OFF_CTRL, 32'h0000_006C);
    wr(`PAC_OFF_CTRL, 32'h0000_0001);
    rd(`PAC_OFF_BUS, 32'h0000_2010);
    send(mk(1'b0, 1'b1, 2'h0, 8'h0F, 5'h09), pac_pkg::PAC_BLOCK);
    send(mk(1'b0, 1'b1, 2'h0, 8'h10, 5'h09), pac_pkg::PAC_ROUTE);
    send(mk(1'b0, 1'b1, 2'h0, 8'h20, 5'h09), pac_pkg::PAC_ROUTE);
    send(mk(1'b0, 1'b0, 2'h0, 8'h21, 5'h08), pac_pkg::PAC_BLOCK);
    send(mk(1'b1, 1'b1, 2'h0, 8'h05, 5'h08), pac_pkg::PAC_ROUTE);
    $display("test source_check done");
    wr(`PAC_OFF_CTRL, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      exp = (i == 0) ? pac_pkg::PAC_ROUTE : pac_pkg::PAC_BLOCK;
      send(mk(1'b0, 1'b1, i[1:0], 8'h10, 5'h09), exp);
    end
    send(mk(1'b0, 1'b0, 2'h1, 8'h10, 5'h09), pac_pkg::PAC_ROUTE);
    send(mk(1'b1, 1'b1, 2'h2, 8'h10, 5'h08), pac_pkg::PAC_ROUTE);
    $display("test translation_block done");
    for (int i = 0; i < 8; i++) begin
      {e, r, v} = i[2:0];
      wr(`PAC_OFF_CTRL, {26'h0, e, 2'h0, r, 2'h0});
      wr(`PAC_OFF_EGRESS, {28'h0, v, 3'h0});
      exp = (r && (v || !e)) ? pac_pkg::PAC_UPSTREAM :
        ((e && !r && v) ? pac_pkg::PAC_BLOCK : pac_pkg::PAC_ROUTE);
      send(mk(1'b0, 1'b1, 2'h0, 8'h10, 5'h18), exp);
      send(mk(1'b0, 1'b1, 2'h0, 8'h10, 5'h10), pac_pkg::PAC_ROUTE);
    end
    $display("test egress_table done");
    wr(`PAC_OFF_CTRL, 32'h0000_0064);
    wr(`PAC_OFF_EGRESS, 32'h0000_0008);
    send(mk(1'b0, 1'b1, 2'h2, 8'h10, 5'h18), pac_pkg::PAC_ROUTE);
    send(mk(1'b0, 1'b1, 2'h0, 8'h10, 5'h18), pac_pkg::PAC_UPSTREAM);
    send(mk(1'b0, 1'b0, 2'h2, 8'h10, 5'h18), pac_pkg::PAC_UPSTREAM);
    $display("test direct_translated done");
    wr(`PAC_OFF_CTRL, 32'h0000_0008);
    send(mk(1'b1, 1'b1, 2'h0, 8'h10, 5'h18), pac_pkg::PAC_UPSTREAM);
    send(mk(1'b1, 1'b1, 2'h0, 8'h10, 5'h1A), pac_pkg::PAC_ROUTE);
    send(mk(1'b1, 1'b0, 2'h0, 8'h10, 5'h18), pac_pkg::PAC_ROUTE);
    send(mk(1'b1, 1'b1, 2'h0, 8'h10, 5'h10), pac_pkg::PAC_ROUTE);
    send(mk(1'b0, 1'b1, 2'h0, 8'h10, 5'h18), pac_pkg::PAC_ROUTE);
    wr(`PAC_OFF_CTRL, 32'h0000_0024);
    send(mk(1'b1, 1'b1, 2'h0, 8'h10, 5'h18), pac_pkg::PAC_ROUTE);
    $display("test completion_redirect done");
    wr(`PAC_OFF_CTRL, 32'h0000_0010);
    send(mk(1'b0, 1'b1, 2'h0, 8'h10, 5'h0D), pac_pkg::PAC_UPSTREAM);
    send(mk(1'b1, 1'b1, 2'h0, 8'h10, 5'h0C), pac_pkg::PAC_UPSTREAM);
    $display("test upstream_forward done");
    rd(`PAC_OFF_VCOUNT, 32'(nviol));
    rd(`PAC_OFF_HDR0, last_hdr[31:0]);
    rd(`PAC_OFF_HDR1, last_hdr[63:32]);
    rd(`PAC_OFF_HDR2, last_hdr[95:64]);
    wr(`PAC_OFF_VCOUNT, 32'h0);
    rd(`PAC_OFF_VCOUNT, 32'h0);
    $display("test violation_log done");
    complete_run();
  end
endmodule
